// >>> ipg_consts.vh
// Constants for the interrupt pulse generator: modes, bit positions, timing.
`ifndef IPG_CONSTS_VH
`define IPG_CONSTS_VH

// ==========
// Operating mode codes, as driven by the device mode controller
// ==========
`define IPG_MODE_W 3
`define IPG_MODE_INIT 3'h0
`define IPG_MODE_NORMAL 3'h1
`define IPG_MODE_STOP 3'h2
`define IPG_MODE_SLEEP 3'h3
`define IPG_MODE_RESTART 3'h4
`define IPG_MODE_FAILSAFE 3'h5

// ==========
// Mask bit positions, one per maskable status group
// ==========
`define IPG_MASK_W 6
`define IPG_MASK_SUPPLY 0
`define IPG_MASK_THERMAL 1
`define IPG_MASK_BUS 2
`define IPG_MASK_HIGHSIDE 3
`define IPG_MASK_BRIDGE 4
`define IPG_MASK_SPI_CRC 5
`define IPG_MASK_RESET 6'h3f

// ==========
// Field positions inside the status registers
// ==========
`define IPG_SUP_POR_BIT 0
`define IPG_SUP_UV_BIT 1
`define IPG_SUP_SC_BIT 2
`define IPG_SUP_OV_BIT 3
`define IPG_THERM_STAGE2_BIT 0
`define IPG_DEV_SPI_FAIL_BIT 0
`define IPG_DEV_CRC_FAIL_BIT 1
`define IPG_DRAIN_SOURCE_OV_REG_BRK_LSB 0
`define IPG_WAKE_LIN_BIT 0
`define IPG_WAKE_PIN_BIT 1
`define IPG_WAKE_TIMER_BIT 2
`define IPG_WAKE_BRAKE_BIT 3

// ==========
// Timing: times in microseconds, counts in cycles of the system clock
// ==========
`define IPG_CLK_MHZ 100
`define IPG_PULSE_TIME_US 100
`define IPG_GAP_TIME_US 100
`define IPG_CYCLIC_TIME_US 10000
`define IPG_PULSE_CYC (`IPG_PULSE_TIME_US * `IPG_CLK_MHZ)
`define IPG_GAP_CYC (`IPG_GAP_TIME_US * `IPG_CLK_MHZ)
`define IPG_CYCLIC_CYC (`IPG_CYCLIC_TIME_US * `IPG_CLK_MHZ)
`define IPG_CNT_W 24

`endif

// >>> ipg_timer.v
// Loadable down-counter used to time pulse, gap and repeat intervals.
`timescale 1ns/1ns

module ipg_timer #(
    parameter CNT_W = 24
) (
    input wire clk_i,               // System clock.
    input wire rst_b_i,             // Synchronised reset, active low.
    input wire start_i,             // Load the length and start counting.
    input wire stop_i,              // Abandon the current interval.
    input wire [CNT_W-1:0] len_i,   // Interval length in cycles, at least 1.
    output wire running_o,          // An interval is in progress.
    output wire done_o              // Last cycle of the interval.
);

    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] count_next;

    // ======================================================================
    // Counter
    // ======================================================================
    // Start wins over stop so that a back-to-back restart is never lost.
    always @*
    begin
        count_next = count_reg;
        if (start_i)
            count_next = len_i;
        else if (stop_i)
            count_next = {CNT_W{1'b0}};
        else if (count_reg != {CNT_W{1'b0}})
            count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count_reg <= {CNT_W{1'b0}};
        else
            count_reg <= count_next;
    end

    // Done marks the final counted cycle, so an interval of N is N cycles.
    assign running_o = (count_reg != {CNT_W{1'b0}});
    assign done_o = (count_reg == {{(CNT_W-1){1'b0}}, 1'b1}) && !stop_i;

endmodule

// >>> ipg_top.v
// Interrupt pulse generator: status latching, masking and pulse timing.
`timescale 1ns/1ns
`include "ipg_consts.vh"

// Notes on behaviour
// - Normal/Stop: drive low one pulse time.
// - Hold output high the minimum gap.
// - Pulses never alter the operating mode.
// - Mask enables each source group separately.
// - Each group source ORs its capable flags.
// - Wake recorded and interrupting only if enabled.
// - Wake sources: LIN, pin, timers, brake.
// - Status and wake interrupts both active together.
// - Restart and fail-safe causes never interrupt.
// - Only SPI/CRC failure flags repeat periodically.
// - No pulse in Restart, Fail-Safe, Sleep.
// - Stop entry pulses if wake/brake pending.
// - Status registers update at once; in a gap ending in a pulse, at its falling edge.
// - Events latched until host clears register.
// - Uncleared SPI/CRC failure flags keep repeating pulses periodically.
// - Cyclic enable bit enables periodic pulses.
// - Simultaneous or overlapping events merge into pulse.
// - In Init the pin selects development mode.
// - Output is push-pull, driving both levels.
module ipg_top #(
    parameter SUP_W = 8,
    parameter THERM_W = 4,
    parameter BUS_W = 4,
    parameter HS_W = 4,
    parameter DRAIN_SOURCE_OV_REG_W = 8,
    parameter BRK_W = 3,
    parameter DEV_W = 4,
    parameter WAKE_W = 4,
    parameter CNT_W = `IPG_CNT_W,
    parameter [CNT_W-1:0] PULSE_CYC = `IPG_PULSE_CYC,
    parameter [CNT_W-1:0] GAP_CYC = `IPG_GAP_CYC,
    parameter [CNT_W-1:0] CYCLIC_CYC = `IPG_CYCLIC_CYC
) (
    input wire clk_sys_i,                       // System clock, 100 MHz.
    input wire rst_b_i,                         // Reset, active low.
    input wire [`IPG_MODE_W-1:0] mode_i,        // Current operating mode.
    input wire [`IPG_MASK_W-1:0] irq_mask_i,    // Group enables, 1 = on.
    input wire cyclic_irq_enable_i,             // Periodic repeat enable.
    input wire [WAKE_W-1:0] wake_src_en_i,      // Wake-up source enables.
    input wire brake_feature_en_i,              // Any brake feature on.
    input wire [SUP_W-1:0] supply_evt_i,        // Supply event strobes.
    input wire [THERM_W-1:0] thermal_evt_i,     // Thermal event strobes.
    input wire [BUS_W-1:0] bus_evt_i,           // Bus event strobes.
    input wire [HS_W-1:0] highside_evt_i,       // High-side fault strobes.
    input wire [DRAIN_SOURCE_OV_REG_W-1:0] drain_source_ov_reg_evt_i,         // Drain-source ov strobes.
    input wire [DEV_W-1:0] device_evt_i,        // Device event strobes.
    input wire [WAKE_W-1:0] wake_evt_i,         // Wake event strobes.
    input wire supply_clr_i,                    // Clear supply flags.
    input wire thermal_clr_i,                   // Clear thermal flags.
    input wire bus_clr_i,                       // Clear bus flags.
    input wire highside_clr_i,                  // Clear high-side flags.
    input wire drain_source_ov_reg_clr_i,                      // Clear drain-source flags.
    input wire device_clr_i,                    // Clear device flags.
    input wire wake_clr_i,                      // Clear wake flags.
    input wire irq_pin_i,                       // Pin level, read in Init.
    output wire [SUP_W-1:0] supply_flags_o,     // Supply status, registered.
    output wire [THERM_W-1:0] thermal_flags_o,  // Thermal status.
    output wire [BUS_W-1:0] bus_flags_o,        // Bus status.
    output wire [HS_W-1:0] highside_fault_o,    // High-side status.
    output wire [DRAIN_SOURCE_OV_REG_W-1:0] drain_source_ov_o, // Drain-source status.
    output wire [DEV_W-1:0] device_flags_o,     // Device status.
    output wire [WAKE_W-1:0] wake_flags_o,      // Wake status.
    output wire irq_out_n_o,                    // Interrupt level, low active.
    output wire irq_oe_o,                       // Pin driver enable.
    output wire sw_dev_sel_o                    // Development mode select.
);

    // ==========
    // Layout of the combined flag vector
    // ==========
    localparam O_THERM = SUP_W;
    localparam O_BUS = O_THERM + THERM_W;
    localparam O_HS = O_BUS + BUS_W;
    localparam O_DRAIN_SOURCE_OV_REG = O_HS + HS_W;
    localparam O_DEV = O_DRAIN_SOURCE_OV_REG + DRAIN_SOURCE_OV_REG_W;
    localparam O_WAKE = O_DEV + DEV_W;
    localparam ALL_W = O_WAKE + WAKE_W;

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_LOW = 2'b01;
    localparam [1:0] ST_GAP = 2'b10;

    // Pulses are allowed only in Normal and Stop.
    function is_active;
        input [`IPG_MODE_W-1:0] m;
        begin
            is_active = (m == `IPG_MODE_NORMAL) || (m == `IPG_MODE_STOP);
        end
    endfunction

    reg rst_s1_reg;
    reg rst_s2_reg;
    wire rst_b;
    reg pin_s1_reg;
    reg pin_s2_reg;
    reg sw_dev_reg;
    reg [`IPG_MODE_W-1:0] mode_prev_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg req_reg;
    reg req_next;
    reg irq_n_reg;
    reg oe_reg;
    reg [ALL_W-1:0] pend_reg;
    reg [ALL_W-1:0] pend_next;
    reg [ALL_W-1:0] vis_reg;
    reg [ALL_W-1:0] vis_next;
    wire active;
    wire [ALL_W-1:0] evt_all;
    wire [ALL_W-1:0] clr_all;
    wire [WAKE_W-1:0] wake_keep;
    wire [WAKE_W-1:0] wake_rec;
    wire [SUP_W-1:0] sup_excl;
    wire [THERM_W-1:0] therm_excl;
    wire [DEV_W-1:0] dev_fail;
    wire [DRAIN_SOURCE_OV_REG_W-1:0] brk_bits;
    wire [`IPG_MASK_W-1:0] group_hit;
    wire status_req;
    wire wake_req;
    wire stop_entry;
    wire cyc_on;
    wire cyc_done;
    wire cyc_run;
    wire new_req;
    wire fire;
    wire xfer;
    wire pulse_done;
    wire gap_done;
    wire pulse_start;
    wire gap_start;

    // ==========
    // Reset release and pin sampling
    // ==========
    // Reset is released through two flops so all logic leaves it together.
    always @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign rst_b = rst_s2_reg;

    // The pin is asynchronous, so it is synchronised before use in Init.
    always @(posedge clk_sys_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            sw_dev_reg <= 1'b0;
            mode_prev_reg <= `IPG_MODE_INIT;
        end
        else
        begin
            pin_s1_reg <= irq_pin_i;
            pin_s2_reg <= pin_s1_reg;
            if (mode_i == `IPG_MODE_INIT)
                sw_dev_reg <= pin_s2_reg;
            mode_prev_reg <= mode_i;
        end
    end

    // ==========
    // Event gathering
    // ==========
    // Brake detection counts as wake-up only with a brake feature enabled.
    assign wake_keep = ~({{(WAKE_W-1){1'b0}}, ~brake_feature_en_i}
                         << `IPG_WAKE_BRAKE_BIT);
    assign wake_rec = wake_evt_i & wake_src_en_i & wake_keep;

    assign evt_all = {wake_rec, device_evt_i, drain_source_ov_reg_evt_i, highside_evt_i,
                      bus_evt_i, thermal_evt_i, supply_evt_i};
    assign clr_all = {{WAKE_W{wake_clr_i}}, {DEV_W{device_clr_i}},
                      {DRAIN_SOURCE_OV_REG_W{drain_source_ov_reg_clr_i}}, {HS_W{highside_clr_i}},
                      {BUS_W{bus_clr_i}}, {THERM_W{thermal_clr_i}},
                      {SUP_W{supply_clr_i}}};

    // Restart and fail-safe causes are recorded but never interrupt.
    assign sup_excl = ({{(SUP_W-1){1'b0}}, 1'b1} << `IPG_SUP_POR_BIT)
                    | ({{(SUP_W-1){1'b0}}, 1'b1} << `IPG_SUP_UV_BIT)
                    | ({{(SUP_W-1){1'b0}}, 1'b1} << `IPG_SUP_SC_BIT)
                    | ({{(SUP_W-1){1'b0}}, 1'b1} << `IPG_SUP_OV_BIT);
    assign therm_excl = {{(THERM_W-1){1'b0}}, 1'b1} << `IPG_THERM_STAGE2_BIT;
    assign dev_fail = ({{(DEV_W-1){1'b0}}, 1'b1} << `IPG_DEV_SPI_FAIL_BIT)
                    | ({{(DEV_W-1){1'b0}}, 1'b1} << `IPG_DEV_CRC_FAIL_BIT);
    assign brk_bits = {{(DRAIN_SOURCE_OV_REG_W-BRK_W){1'b0}}, {BRK_W{1'b1}}}
                      << `IPG_DRAIN_SOURCE_OV_REG_BRK_LSB;

    // Group sources, each the OR of its interrupt-capable bits.
    assign group_hit[`IPG_MASK_SUPPLY] =
        |(supply_evt_i & ~sup_excl);
    assign group_hit[`IPG_MASK_THERMAL] =
        |(thermal_evt_i & ~therm_excl);
    assign group_hit[`IPG_MASK_BUS] = |bus_evt_i;
    assign group_hit[`IPG_MASK_HIGHSIDE] = |highside_evt_i;
    assign group_hit[`IPG_MASK_BRIDGE] = |drain_source_ov_reg_evt_i;
    assign group_hit[`IPG_MASK_SPI_CRC] = |(device_evt_i & dev_fail);

    // A masked group's events never ask for a pulse; its brake bits still count at Stop entry.
    assign status_req = |(group_hit & irq_mask_i);
    assign wake_req = |wake_rec;

    // Entering Stop with uncleared wake or brake bits asks for a pulse.
    assign stop_entry = (mode_i == `IPG_MODE_STOP)
                     && (mode_prev_reg != `IPG_MODE_STOP)
                     && ((|vis_reg[O_WAKE +: WAKE_W])
                         || (|(vis_reg[O_DRAIN_SOURCE_OV_REG +: DRAIN_SOURCE_OV_REG_W] & brk_bits)));

    // ==========
    // Periodic repeat for uncleared failure flags
    // ==========
    // Only the SPI and CRC failure flags keep the repeat timer running.
    assign cyc_on = active && cyclic_irq_enable_i
                 && irq_mask_i[`IPG_MASK_SPI_CRC]
                 && (|(vis_reg[O_DEV +: DEV_W] & dev_fail));

    ipg_timer #(
        .CNT_W(CNT_W)
    ) u_cyc_timer (
        .clk_i(clk_sys_i),
        .rst_b_i(rst_b),
        .start_i(cyc_on && (!cyc_run || cyc_done)), // Reload at expiry.
        .stop_i(!cyc_on),
        .len_i(CYCLIC_CYC),
        .running_o(cyc_run),
        .done_o(cyc_done)
    );

    // Both request methods are served side by side.
    assign new_req = status_req || wake_req || stop_entry
                  || cyc_done;
    assign active = is_active(mode_i);
    assign fire = active && (req_reg || new_req);

    // ==========
    // Pulse sequencer
    // ==========
    // One timer serves pulse and gap, since they never overlap.
    ipg_timer #(
        .CNT_W(CNT_W)
    ) u_pulse_timer (
        .clk_i(clk_sys_i),
        .rst_b_i(rst_b),
        .start_i(pulse_start || gap_start),
        .stop_i(!active),
        .len_i(gap_start ? GAP_CYC : PULSE_CYC),
        .running_o(),
        .done_o(pulse_done)
    );

    assign gap_done = pulse_done && (state_reg == ST_GAP);
    assign gap_start = pulse_done && (state_reg == ST_LOW);
    assign pulse_start = fire && ((state_reg == ST_IDLE) || gap_done);

    // The sequencer only reads the mode; it has no path to change it.
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (fire)
                    state_next = ST_LOW;
            end
            ST_LOW:
            begin
                if (pulse_done)
                    state_next = ST_GAP;
            end
            ST_GAP:
            begin
                if (gap_done)
                    state_next = fire ? ST_LOW : ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        if (!active)
            state_next = ST_IDLE;
    end

    // Requests seen while low, except in its last cycle, are part of the current pulse.
    always @*
    begin
        req_next = req_reg || new_req;
        if (!active || (state_next == ST_LOW))
            req_next = 1'b0;
    end

    // ==========
    // Status latching
    // ==========
    // Events are held back only in a gap that ends in a pulse, and show at
    // its falling edge. With no pulse coming they show at once, so a masked
    // or excluded event is never stranded out of the host's sight.
    assign xfer = (state_next != ST_GAP) || !req_next;

    // A set arriving with a clear wins, so no event is ever lost.
    always @*
    begin
        pend_next = xfer ? {ALL_W{1'b0}} : (pend_reg | evt_all);
        vis_next = (vis_reg & ~clr_all)
                 | (xfer ? (pend_reg | evt_all) : {ALL_W{1'b0}});
    end

    always @(posedge clk_sys_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            req_reg <= 1'b0;
            pend_reg <= {ALL_W{1'b0}};
            vis_reg <= {ALL_W{1'b0}};
            irq_n_reg <= 1'b1;
            oe_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            req_reg <= req_next;
            pend_reg <= pend_next;
            vis_reg <= vis_next;
            irq_n_reg <= (state_next != ST_LOW);
            oe_reg <= (mode_i != `IPG_MODE_INIT);
        end
    end

    // ==========
    // Outputs
    // ==========
    // Push-pull: while enabled the level is driven both high and low.
    assign irq_out_n_o = irq_n_reg;
    assign irq_oe_o = oe_reg;
    assign sw_dev_sel_o = sw_dev_reg;
    assign supply_flags_o = vis_reg[0 +: SUP_W];
    assign thermal_flags_o = vis_reg[O_THERM +: THERM_W];
    assign bus_flags_o = vis_reg[O_BUS +: BUS_W];
    assign highside_fault_o = vis_reg[O_HS +: HS_W];
    assign drain_source_ov_o = vis_reg[O_DRAIN_SOURCE_OV_REG +: DRAIN_SOURCE_OV_REG_W];
    assign device_flags_o = vis_reg[O_DEV +: DEV_W];
    assign wake_flags_o = vis_reg[O_WAKE +: WAKE_W];

endmodule

// >>> ipg_host_model.sv
// Host model: watches the interrupt line, drives the pin and clears flags.
`timescale 1ns/1ns

module ipg_host_model #(
    parameter int CLR_DELAY = 3
) (
    input wire logic clk_i,       // System clock.
    input wire logic irq_n_i,     // Interrupt level from the device.
    input wire logic irq_oe_i,    // Device pin driver enable.
    input wire logic sel_i,       // Level the host drives when allowed.
    input wire logic auto_clr_i,  // Clear device flags after a pulse.
    output logic pin_o,           // Resolved pin level.
    output logic clr_o,           // One-cycle clear of the device flags.
    output logic [7:0] falls_o    // Pulses seen so far.
);
    logic last_n = 1'b1;
    logic [3:0] wait_cnt = 4'h0;

    // ==========
    // Pin and pulse handling
    // The device wins the wire whenever it drives; the host only fills in.
    assign pin_o = irq_oe_i ? irq_n_i : sel_i;

    initial
    begin
        falls_o = 8'h00;
        clr_o = 1'b0;
    end

    // Each falling edge is counted and, with auto_clr_i set, later answered by a clear.
    always @(posedge clk_i)
    begin
        last_n <= irq_n_i;
        clr_o <= 1'b0;
        if (last_n && !irq_n_i)
        begin
            falls_o <= falls_o + 8'h01;
            wait_cnt <= CLR_DELAY[3:0];
        end
        else if (wait_cnt != 4'h0)
        begin
            wait_cnt <= wait_cnt - 4'h1;
            clr_o <= auto_clr_i && (wait_cnt == 4'h1);
        end
    end
endmodule

// >>> ipg_top_sva.sv
// Checker for the interrupt pulse generator, bound to its top ports.
`timescale 1ns/1ns
`include "ipg_consts.vh"

module ipg_top_sva #(
    parameter int PULSE_CYC = 8,
    parameter int GAP_CYC = 4,
    parameter int DEV_W = 4,
    parameter int WAKE_W = 4,
    parameter int DRAIN_SOURCE_OV_REG_W = 8
) (
    input wire clk_sys_i,                     // System clock.
    input wire rst_b_i,                       // Reset, active low.
    input wire [`IPG_MODE_W-1:0] mode_i,      // Operating mode.
    input wire [DEV_W-1:0] device_evt_i,      // Device events.
    input wire device_clr_i,                  // Device flag clear.
    input wire [DEV_W-1:0] device_flags_o,    // Device flags.
    input wire [WAKE_W-1:0] wake_flags_o,     // Wake flags.
    input wire [DRAIN_SOURCE_OV_REG_W-1:0] drain_source_ov_o, // Drain-source flags.
    input wire irq_out_n_o,                   // Interrupt level.
    input wire irq_oe_o                       // Pin driver enable.
);
    reg [7:0] low_cnt;
    reg [7:0] high_cnt;
    reg [2:0] age;
    wire act = (mode_i == `IPG_MODE_NORMAL) || (mode_i == `IPG_MODE_STOP);
    wire rdy = (age >= 3'h3);

    // ==========
    // Run lengths; the gap count saturates, so reset leaves no short gap.
    always @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            low_cnt <= 8'h00;
            high_cnt <= GAP_CYC[7:0];
            age <= 3'h0;
        end
        else
        begin
            low_cnt <= irq_out_n_o ? 8'h00 : low_cnt + 8'h01;
            high_cnt <= !irq_out_n_o ? 8'h00 :
                (high_cnt >= GAP_CYC[7:0]) ? high_cnt : high_cnt + 8'h01;
            age <= (age == 3'h7) ? age : age + 3'h1;
        end
    end

    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // Stop entry with flags left over, then a pulse shortly after.
    sequence stop_enter;
        rdy && mode_i == `IPG_MODE_STOP && $past(mode_i) != `IPG_MODE_STOP
            && irq_out_n_o
            && (wake_flags_o != 0 || drain_source_ov_o[2:0] != 0);
    endsequence
    sequence low_soon;
        ##[1:8] !irq_out_n_o;
    endsequence

    pulse_len_a: assert property (
        $rose(irq_out_n_o) && act && $past(act) |-> low_cnt == PULSE_CYC)
        else $error("Pulse length wrong.");
    low_cap_a: assert property (low_cnt <= PULSE_CYC)
        else $error("Pulse too long.");
    gap_min_a: assert property (
        $fell(irq_out_n_o) |-> high_cnt >= GAP_CYC)
        else $error("Gap too short.");
    quiet_mode_a: assert property (!act |=> irq_out_n_o)
        else $error("Pulse in quiet mode.");
    drive_both_a: assert property (
        rdy && mode_i != `IPG_MODE_INIT |=> irq_oe_o)
        else $error("Driver off.");
    init_pin_a: assert property (
        mode_i == `IPG_MODE_INIT |=> !irq_oe_o)
        else $error("Driven in Init.");
    dev_hold_a: assert property (
        act && !device_clr_i && device_evt_i == 0
            |=> $stable(device_flags_o) || $fell(irq_out_n_o))
        else $error("Device flags moved.");
    dev_clear_a: assert property (
        device_clr_i && device_evt_i == 0 |=> device_flags_o == 0)
        else $error("Device flags not cleared.");
    stop_entry_a: assert property (stop_enter |-> low_soon)
        else $error("No Stop entry pulse.");
endmodule

bind ipg_top ipg_top_sva #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC),
    .DEV_W(DEV_W), .WAKE_W(WAKE_W), .DRAIN_SOURCE_OV_REG_W(DRAIN_SOURCE_OV_REG_W)) u_ipg_top_sva (
    .clk_sys_i, .rst_b_i, .mode_i, .device_evt_i, .device_clr_i,
    .device_flags_o, .wake_flags_o, .drain_source_ov_o, .irq_out_n_o,
    .irq_oe_o);

// >>> ipg_top_tb.sv
// Self-checking testbench for the interrupt pulse generator.
`timescale 1ns/1ns
`include "ipg_consts.vh"

module ipg_top_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] mode_i = `IPG_MODE_NORMAL;
    logic [5:0] mask = `IPG_MASK_RESET;
    logic cyc_en = 1'b0, brk_en = 1'b0, sel = 1'b0, auto_clr = 1'b0;
    logic [3:0] wake_en = 4'h0, th_e = 4'h0, bus_e = 4'h0, hs_e = 4'h0;
    logic [3:0] dev_e = 4'h0, wk_e = 4'h0;
    logic [7:0] sup_e = 8'h00, drain_source_ov_reg_e = 8'h00, n0;
    logic [6:0] clr = 7'h00;
    wire [7:0] sup_f, drain_source_ov_reg_f, falls;
    wire [3:0] th_f, bus_f, hs_f, dev_f, wk_f;
    wire irq_n, oe, dev_sel, pin, host_clr;
    int fail_count = 0, checks_done = 0, cycles = 0;

    ipg_top #(.PULSE_CYC(24'h00_0008), .GAP_CYC(24'h00_0004),
        .CYCLIC_CYC(24'h00_0028)) u_ipg_top (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .mode_i(mode_i),
        .irq_mask_i(mask), .cyclic_irq_enable_i(cyc_en),
        .wake_src_en_i(wake_en), .brake_feature_en_i(brk_en),
        .supply_evt_i(sup_e), .thermal_evt_i(th_e), .bus_evt_i(bus_e),
        .highside_evt_i(hs_e), .drain_source_ov_reg_evt_i(drain_source_ov_reg_e), .device_evt_i(dev_e),
        .wake_evt_i(wk_e), .supply_clr_i(clr[0]), .thermal_clr_i(clr[1]),
        .bus_clr_i(clr[2]), .highside_clr_i(clr[3]), .drain_source_ov_reg_clr_i(clr[4]),
        .device_clr_i(clr[5] | host_clr), .wake_clr_i(clr[6]),
        .irq_pin_i(pin), .supply_flags_o(sup_f), .thermal_flags_o(th_f),
        .bus_flags_o(bus_f), .highside_fault_o(hs_f),
        .drain_source_ov_o(drain_source_ov_reg_f), .device_flags_o(dev_f),
        .wake_flags_o(wk_f), .irq_out_n_o(irq_n), .irq_oe_o(oe),
        .sw_dev_sel_o(dev_sel));
    ipg_host_model u_ipg_host_model (.clk_i(clk_sys_i), .irq_n_i(irq_n),
        .irq_oe_i(oe), .sel_i(sel), .auto_clr_i(auto_clr), .pin_o(pin),
        .clr_o(host_clr), .falls_o(falls));

    // ==========
    // Clock, time limit and shared helpers
    initial
        forever #5 clk_sys_i = ~clk_sys_i;

    // The limit is well above the roughly 1100 cycles the run needs.
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle event strobe on bit b of group g; group 6 is wake.
    task automatic fire(input int g, input int b);
        case (g)
            0: sup_e[b] = 1'b1;
            1: th_e[b] = 1'b1;
            2: bus_e[b] = 1'b1;
            3: hs_e[b] = 1'b1;
            4: drain_source_ov_reg_e[b] = 1'b1;
            5: dev_e[b] = 1'b1;
            default: wk_e[b] = 1'b1;
        endcase
        step(1);
        {sup_e, drain_source_ov_reg_e, th_e, bus_e, hs_e, dev_e, wk_e} = '0;
    endtask

    task automatic clear_all;
        clr = 7'h7f;
        step(1);
        clr = 7'h00;
    endtask

    task automatic got(input int n, input logic [7:0] exp);
        step(n);
        check(falls - n0, exp);
        n0 = falls;
    endtask

    // Twenty cycles cover one pulse and its gap.
    task automatic hit(input int g, input int b, input logic [7:0] exp);
        n0 = falls;
        fire(g, b);
        got(20, exp);
    endtask

    // ==========
    // Scenarios
    task automatic t_groups;
        for (int g = 0; g < 6; g++)
        begin
            mask = 6'h01 << g;
            hit(g, (g == 0) ? 4 : 1, 1);
            clear_all;
            mask = ~(6'h01 << g);
            hit(g, (g == 0) ? 4 : 1, 0);
            check(|{sup_f, th_f, bus_f, hs_f, drain_source_ov_reg_f, dev_f}, 1);
            clear_all;
        end
    endtask

    task automatic t_excl;
        mask = 6'h3f;
        for (int b = 0; b < 4; b++)
            fire(0, b);
        fire(1, 0);
        got(20, 0);
        check(sup_f, 8'h0f);
        clear_all;
    endtask

    task automatic t_wake;
        mask = 6'h00;
        brk_en = 1'b1;
        for (int b = 0; b < 4; b++)
        begin
            wake_en = 4'h0;
            hit(6, b, 0);
            wake_en = 4'h1 << b;
            hit(6, b, 1);
            check(wk_f, 4'h1 << b);
            clear_all;
        end
        brk_en = 1'b0;
        hit(6, 3, 0);
        check(wk_f, 4'h0);
    endtask

    // Second event merges into the low phase, third waits out the gap.
    task automatic t_merge;
        mask = 6'h3f;
        fire(0, 4);
        step(2);
        fire(1, 1);
        step(5);
        fire(2, 1);
        got(30, 2);
        check(bus_f, 4'h2);
        clear_all;
    endtask

    task automatic t_cyclic;
        cyc_en = 1'b1;
        fire(5, 0);
        got(100, 3);
        cyc_en = 1'b0;
        got(100, 0);
        clear_all;
        cyc_en = 1'b1;
        fire(0, 4);
        got(100, 1);
        clear_all;
        auto_clr = 1'b1;
        fire(5, 1);
        got(100, 1);
        check(dev_f, 4'h0);
        auto_clr = 1'b0;
        cyc_en = 1'b0;
    endtask

    task automatic t_modes;
        for (int i = 3; i < 6; i++)
        begin
            mode_i = i[2:0];
            hit(0, 4, 0);
            check(oe, 1'b1);
            clear_all;
        end
        mode_i = `IPG_MODE_NORMAL;
        fire(0, 4);
        step(3);
        mode_i = `IPG_MODE_SLEEP;
        step(2);
        check(irq_n, 1'b1);
        clear_all;
        mode_i = `IPG_MODE_NORMAL;
        step(10);
    endtask

    task automatic t_stop;
        mask = 6'h00;
        wake_en = 4'hf;
        hit(6, 0, 1);
        for (int k = 0; k < 2; k++)
        begin
            mode_i = `IPG_MODE_STOP;
            got(20, 1);
            mode_i = `IPG_MODE_NORMAL;
            clear_all;
            hit(4, 0, 0);
        end
        clear_all;
    endtask

    task automatic t_init;
        mode_i = `IPG_MODE_INIT;
        sel = 1'b1;
        step(5);
        check(oe, 1'b0);
        check(dev_sel, 1'b1);
        sel = 1'b0;
        step(5);
        check(dev_sel, 1'b0);
        mode_i = `IPG_MODE_NORMAL;
        step(3);
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_b_i = 1'b1;
        step(4);
        t_groups();
        t_excl();
        t_wake();
        t_merge();
        t_cyclic();
        t_modes();
        t_stop();
        t_init();
        wrap_up();
    end
endmodule
